/* rtl/tpb_pkg.sv */
package tpb_pkg;
  // stage kinds
  typedef enum logic [2:0] {
    TPB_STAGE_VS = 3'h0,
    TPB_STAGE_GS = 3'h1,
    TPB_STAGE_CLIP = 3'h2,
    TPB_STAGE_SF = 3'h3,
    TPB_STAGE_WM = 3'h4
  } tpb_stage_t;

  // register byte offsets
  localparam logic [7:0] TPB_OFF_CTRL = 8'h00;
  localparam logic [7:0] TPB_OFF_SCR_BASE = 8'h04;
  localparam logic [7:0] TPB_OFF_SCR_SIZE = 8'h08;
  localparam logic [7:0] TPB_OFF_BIND = 8'h0C;
  localparam logic [7:0] TPB_OFF_SAMP = 8'h10;
  localparam logic [7:0] TPB_OFF_READ = 8'h14;
  localparam logic [7:0] TPB_OFF_DBG = 8'h18;
  localparam logic [7:0] TPB_OFF_STATUS = 8'h1C;

  // ctrl fields: [2:0] stage, [7:4] unit id, [15:8] start register
  localparam int TPB_CTRL_STAGE_LSB = 0;
  localparam int TPB_CTRL_UNIT_LSB = 4;
  localparam int TPB_CTRL_START_LSB = 8;
  // read fields: [7:0] const off, [15:8] const len, [23:16] vtx off, [31:24] vtx len
  localparam int TPB_RD_COFF_LSB = 0;
  localparam int TPB_RD_CLEN_LSB = 8;
  localparam int TPB_RD_VOFF_LSB = 16;
  localparam int TPB_RD_VLEN_LSB = 24;

  localparam logic [31:0] TPB_CTRL_RST = 32'h0000_0100;
  localparam logic [31:0] TPB_READ_RST = 32'h0100_0000;

  // header sizes in thread registers
  localparam logic [7:0] TPB_HDR_ONE = 8'h01;
  localparam logic [7:0] TPB_HDR_SF = 8'h03;
  localparam logic [7:0] TPB_HDR_WM = 8'h02;

  // granularities and codes
  localparam int TPB_GRAN64_SHIFT = 6;
  localparam logic [4:0] TPB_TOPO_STRIP = 5'h06;
  localparam logic [4:0] TPB_TOPO_STRIP_REV = 5'h12;
  localparam int TPB_SLOTS = 4;
  localparam int TPB_SLOT_W = 2;
  localparam logic [31:0] TPB_AXI_OKAY = 32'h0;
  localparam logic [1:0] TPB_RESP_OKAY = 2'h0;
  localparam logic [1:0] TPB_RESP_SLVERR = 2'h2;

  // header word kinds on the header output
  localparam logic [2:0] TPB_HW_IDS = 3'h0;
  localparam logic [2:0] TPB_HW_SCRATCH = 3'h1;
  localparam logic [2:0] TPB_HW_TABLES = 3'h2;
  localparam logic [2:0] TPB_HW_LINK0 = 3'h3;
  localparam logic [2:0] TPB_HW_LINK1 = 3'h4;
  localparam logic [2:0] TPB_HW_TOPO = 3'h5;
endpackage

/* rtl/tpb_slot_pool.sv */
`timescale 1ns/1ps
`default_nettype none
// active-slot pool: lends slot indices, takes them back at end
module tpb_slot_pool
  import tpb_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic alloc,
  input wire logic release_en,
  input wire logic [TPB_SLOT_W-1:0] release_idx,
  output logic any_free,
  output logic [TPB_SLOT_W-1:0] free_idx,
  output logic [TPB_SLOTS-1:0] busy
);
  logic [TPB_SLOTS-1:0] busy_q;
  logic [TPB_SLOTS-1:0] free_onehot;

  // lowest free slot wins
  always_comb begin
    free_onehot = '0;
    free_idx = '0;
    for (int i = TPB_SLOTS - 1; i >= 0; i--) begin
      if (!busy_q[i]) begin
        free_onehot = '0;
        free_onehot[i] = 1'b1;
        free_idx = TPB_SLOT_W'(i);
      end
    end
  end

  assign any_free = ~&busy_q;
  assign busy = busy_q;

  // per slot busy flag; allocation beats release of same slot
  genvar g;
  generate
    for (g = 0; g < TPB_SLOTS; g++) begin : g_slot
      always_ff @(posedge core_clk) begin
        if (srst) begin
          busy_q[g] <= 1'b0;
        end else if (alloc && any_free && free_onehot[g]) begin
          busy_q[g] <= 1'b1;
        end else if (release_en && release_idx == TPB_SLOT_W'(g)) begin
          busy_q[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/tpb_payload_builder.sv */
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - own unit id in header; matched on snooped messages
// - snapshot flag set only on debug match
// - long-lived unique thread id apart from slot
// - slot index picks handle pool, frees scratch at end
// - scratch start is base plus slot times size
// - binding table as 64-byte granule offset
// - sampler table only for vertex, geometry, windower
// - entry link id per thread; flags entry writes
// - link pairs: one, vertex one or two, windower none
// - topology passed except vertex stage; strips may toggle
// - extended header for setup and windower
// - entry data at programmable start register
// - constant entry first, then primitive or vertex entries
// - handle, offset, length issued per entry
// - constant offset in rows from entry start
// - constant length in rows; zero reads nothing
// - same vertex offset for every vertex entry
// - payload from register zero, header first
// - header one register, setup three, windower two
module tpb_payload_builder
  import tpb_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // dispatch request from the stage pipeline
  input wire logic disp_valid,
  output logic disp_ready,
  input wire logic [4:0] disp_topology,
  input wire logic disp_flip_strip,
  input wire logic disp_two_vertices,
  input wire logic [2:0] disp_vertex_count,
  input wire logic [15:0] disp_const_handle,
  input wire logic [15:0] disp_entry_handle0,
  input wire logic [15:0] disp_entry_handle1,
  input wire logic [7:0] disp_link_id0,
  input wire logic [7:0] disp_link_id1,
  // header words toward the thread register array
  output logic hdr_valid,
  output logic [2:0] hdr_kind,
  output logic [7:0] hdr_reg,
  output logic [31:0] hdr_word,
  // entry read sequences toward the shared subsystem
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [15:0] rd_handle,
  output logic [7:0] rd_offset,
  output logic [7:0] rd_length,
  output logic [7:0] rd_dest_reg,
  output logic rd_swizzle,
  output logic disp_done,
  // message snoop toward the shared entry buffer
  input wire logic msg_valid,
  input wire logic [3:0] msg_unit_id,
  input wire logic [1:0] msg_slot,
  input wire logic [7:0] msg_link_id,
  input wire logic msg_alloc,
  input wire logic msg_eot,
  output logic own_write_seen,
  output logic [7:0] own_write_link,
  output logic alloc_req,
  output logic [1:0] alloc_pool,
  output logic scratch_free
);
  typedef enum logic [2:0] {
    TPB_IDLE = 3'b000,
    TPB_HDR = 3'b001,
    TPB_CONST = 3'b011,
    TPB_VERT = 3'b010,
    TPB_DONE = 3'b110
  } tpb_state_t;

  logic [31:0] ctrl_q, scr_base_q, scr_size_q, bind_q, samp_q, read_q, dbg_q;
  logic [15:0] thread_id_q;
  logic [15:0] snap_cnt_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  tpb_state_t state_q;
  logic [2:0] hdr_idx_q;
  logic [2:0] vtx_idx_q;
  logic [2:0] vtx_total_q;
  logic [7:0] dest_q;
  logic [1:0] slot_q;
  logic snap_q;
  logic [4:0] topo_q;
  logic [15:0] ch_q, eh0_q, eh1_q;
  logic [7:0] l0_q, l1_q;
  logic pool_free;
  logic [1:0] pool_idx;
  logic [TPB_SLOTS-1:0] pool_busy;

  tpb_stage_t stage;
  logic [3:0] unit_id;
  logic [7:0] start_reg, c_off, c_len, v_off, v_len, hdr_size;
  logic take;
  logic [2:0] hdr_last;

  assign stage = tpb_stage_t'(ctrl_q[TPB_CTRL_STAGE_LSB +: 3]);
  assign unit_id = ctrl_q[TPB_CTRL_UNIT_LSB +: 4];
  assign start_reg = ctrl_q[TPB_CTRL_START_LSB +: 8];
  assign c_off = read_q[TPB_RD_COFF_LSB +: 8];
  assign c_len = read_q[TPB_RD_CLEN_LSB +: 8];
  assign v_off = read_q[TPB_RD_VOFF_LSB +: 8];
  assign v_len = read_q[TPB_RD_VLEN_LSB +: 8];
  assign take = disp_valid && disp_ready;

  // header length per stage; setup and windower extension puts the topology word in register 1
  always_comb begin
    unique case (stage)
      TPB_STAGE_SF: hdr_size = TPB_HDR_SF;
      TPB_STAGE_WM: hdr_size = TPB_HDR_WM;
      default: hdr_size = TPB_HDR_ONE;
    endcase
  end

  // last header word; vertex stage has no topology word
  always_comb begin
    unique case (stage)
      TPB_STAGE_VS: hdr_last = TPB_HW_LINK1;
      default: hdr_last = TPB_HW_TOPO;
    endcase
  end

  tpb_slot_pool u_pool (
    .core_clk(core_clk),
    .srst(srst),
    .alloc(take),
    .release_en(msg_valid && msg_eot && msg_unit_id == unit_id),
    .release_idx(msg_slot),
    .any_free(pool_free),
    .free_idx(pool_idx),
    .busy(pool_busy)
  );

  // write side: answer once address and data are both held
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TPB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q <= TPB_OFF_DBG && aw_addr_q[1:0] == 2'h0) ?
                       TPB_RESP_OKAY : TPB_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;

  function automatic logic [31:0] tpb_merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  // register writes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= TPB_CTRL_RST;
      scr_base_q <= 32'h0000_0000;
      scr_size_q <= 32'h0000_0000;
      bind_q <= 32'h0000_0000;
      samp_q <= 32'h0000_0000;
      read_q <= TPB_READ_RST;
      dbg_q <= 32'h0000_0000;
    end else if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
      unique case (aw_addr_q)
        TPB_OFF_CTRL: ctrl_q <= tpb_merge(ctrl_q, w_data_q, w_strb_q);
        TPB_OFF_SCR_BASE: scr_base_q <= tpb_merge(scr_base_q, w_data_q, w_strb_q);
        TPB_OFF_SCR_SIZE: scr_size_q <= tpb_merge(scr_size_q, w_data_q, w_strb_q);
        TPB_OFF_BIND: bind_q <= tpb_merge(bind_q, w_data_q, w_strb_q);
        TPB_OFF_SAMP: samp_q <= tpb_merge(samp_q, w_data_q, w_strb_q);
        TPB_OFF_READ: read_q <= tpb_merge(read_q, w_data_q, w_strb_q);
        TPB_OFF_DBG: dbg_q <= tpb_merge(dbg_q, w_data_q, w_strb_q);
        default: ;
      endcase
    end
  end

  // read side: answer the cycle after the address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TPB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= TPB_RESP_OKAY;
      unique case (s_axi_araddr)
        TPB_OFF_CTRL: s_axi_rdata <= ctrl_q;
        TPB_OFF_SCR_BASE: s_axi_rdata <= scr_base_q;
        TPB_OFF_SCR_SIZE: s_axi_rdata <= scr_size_q;
        TPB_OFF_BIND: s_axi_rdata <= bind_q;
        TPB_OFF_SAMP: s_axi_rdata <= samp_q;
        TPB_OFF_READ: s_axi_rdata <= read_q;
        TPB_OFF_DBG: s_axi_rdata <= dbg_q;
        TPB_OFF_STATUS: s_axi_rdata <= {thread_id_q, 8'h00, 1'b0, state_q, pool_busy};
        default: begin
          s_axi_rdata <= TPB_AXI_OKAY;
          s_axi_rresp <= TPB_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // dispatch accepted only when idle and a slot is free
  assign disp_ready = (state_q == TPB_IDLE) && pool_free;

  // sequencer: header, constant entry, then entries
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= TPB_IDLE;
      hdr_idx_q <= 3'h0;
      vtx_idx_q <= 3'h0;
      vtx_total_q <= 3'h0;
      dest_q <= 8'h00;
    end else begin
      unique case (state_q)
        TPB_IDLE: begin
          if (take) begin
            state_q <= TPB_HDR;
            hdr_idx_q <= TPB_HW_IDS;
            vtx_idx_q <= 3'h0;
            dest_q <= start_reg;
            if (stage == TPB_STAGE_WM) begin
              vtx_total_q <= 3'h1; // one primitive entry
            end else if (stage == TPB_STAGE_VS) begin
              vtx_total_q <= disp_two_vertices ? 3'h2 : 3'h1;
            end else begin
              vtx_total_q <= disp_vertex_count;
            end
          end
        end
        TPB_HDR: begin
          if (hdr_idx_q == hdr_last) begin
            state_q <= (c_len != 8'h00) ? TPB_CONST : TPB_VERT;
          end else begin
            hdr_idx_q <= hdr_idx_q + 3'h1;
          end
        end
        TPB_CONST: begin
          if (rd_ready) begin
            state_q <= TPB_VERT;
            dest_q <= dest_q + c_len;
          end
        end
        TPB_VERT: begin
          if (vtx_idx_q == vtx_total_q) begin
            state_q <= TPB_DONE;
          end else if (rd_ready) begin
            vtx_idx_q <= vtx_idx_q + 3'h1;
            dest_q <= dest_q + v_len;
          end
        end
        TPB_DONE: state_q <= TPB_IDLE;
        default: state_q <= TPB_IDLE;
      endcase
    end
  end

  // per-dispatch captured fields
  always_ff @(posedge core_clk) begin
    if (srst) begin
      slot_q <= 2'h0;
      snap_q <= 1'b0;
      topo_q <= 5'h00;
      ch_q <= 16'h0000;
      eh0_q <= 16'h0000;
      eh1_q <= 16'h0000;
      l0_q <= 8'h00;
      l1_q <= 8'h00;
    end else if (take) begin
      slot_q <= pool_idx;
      // debug match: enable bit 31, period in low bits
      snap_q <= dbg_q[31] && (snap_cnt_q == dbg_q[15:0]);
      if (disp_flip_strip && disp_topology == TPB_TOPO_STRIP) begin
        topo_q <= TPB_TOPO_STRIP_REV;
      end else if (disp_flip_strip && disp_topology == TPB_TOPO_STRIP_REV) begin
        topo_q <= TPB_TOPO_STRIP;
      end else begin
        topo_q <= disp_topology;
      end
      ch_q <= disp_const_handle;
      eh0_q <= disp_entry_handle0;
      eh1_q <= disp_entry_handle1;
      l0_q <= disp_link_id0;
      l1_q <= disp_link_id1;
    end
  end

  // thread id free-runs per dispatch; wraps only after 65536 threads
  always_ff @(posedge core_clk) begin
    if (srst) begin
      thread_id_q <= 16'h0000;
      snap_cnt_q <= 16'h0000;
    end else if (take) begin
      thread_id_q <= thread_id_q + 16'h0001;
      snap_cnt_q <= (snap_q || snap_cnt_q == dbg_q[15:0]) ? 16'h0000 : snap_cnt_q + 16'h0001;
    end
  end

  // header word output
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hdr_valid <= 1'b0;
      hdr_kind <= 3'h0;
      hdr_reg <= 8'h00;
      hdr_word <= 32'h0000_0000;
    end else begin
      hdr_valid <= 1'b0;
      if (state_q == TPB_HDR) begin
        hdr_kind <= hdr_idx_q;
        hdr_reg <= (hdr_idx_q == TPB_HW_TOPO && hdr_size > TPB_HDR_ONE) ? 8'h01 : 8'h00;
        unique case (hdr_idx_q)
          TPB_HW_IDS: begin
            hdr_valid <= 1'b1;
            hdr_word <= {thread_id_q - 16'h0001, 5'h00, snap_q, slot_q, 4'h0, unit_id};
          end
          TPB_HW_SCRATCH: begin
            hdr_valid <= 1'b1;
            hdr_word <= scr_base_q + 32'(slot_q) * scr_size_q;
          end
          TPB_HW_TABLES: begin
            hdr_valid <= 1'b1;
            hdr_word[15:0] <= bind_q[TPB_GRAN64_SHIFT +: 16];
            hdr_word[31:16] <= (stage inside {TPB_STAGE_VS, TPB_STAGE_GS, TPB_STAGE_WM}) ?
                               samp_q[TPB_GRAN64_SHIFT +: 16] : 16'h0000;
          end
          TPB_HW_LINK0: begin
            hdr_valid <= (stage != TPB_STAGE_WM);
            hdr_word <= {l0_q, 8'h00, eh0_q};
          end
          TPB_HW_LINK1: begin
            hdr_valid <= (stage == TPB_STAGE_VS) && (vtx_total_q == 3'h2);
            hdr_word <= {l1_q, 8'h00, eh1_q};
          end
          TPB_HW_TOPO: begin
            hdr_valid <= (stage != TPB_STAGE_VS);
            hdr_word <= {27'h0, topo_q};
          end
          default: hdr_valid <= 1'b0;
        endcase
      end
    end
  end

  // entry read request, held while waiting for ready
  always_comb begin
    rd_valid = 1'b0;
    rd_handle = 16'h0000;
    rd_offset = 8'h00;
    rd_length = 8'h00;
    if (state_q == TPB_CONST) begin
      rd_valid = 1'b1;
      rd_handle = ch_q;
      rd_offset = c_off;
      rd_length = c_len;
    end else if (state_q == TPB_VERT && vtx_idx_q != vtx_total_q) begin
      rd_valid = 1'b1;
      rd_handle = (vtx_idx_q == 3'h0) ? eh0_q : eh1_q;
      rd_offset = v_off;
      rd_length = v_len;
    end
  end
  assign rd_dest_reg = dest_q;
  assign rd_swizzle = (stage == TPB_STAGE_VS);
  assign disp_done = (state_q == TPB_DONE);

  // snoop of messages to the shared entry buffer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      own_write_seen <= 1'b0;
      own_write_link <= 8'h00;
      alloc_req <= 1'b0;
      alloc_pool <= 2'h0;
      scratch_free <= 1'b0;
    end else begin
      own_write_seen <= msg_valid && msg_unit_id == unit_id;
      own_write_link <= msg_link_id;
      alloc_req <= msg_valid && msg_unit_id == unit_id && msg_alloc;
      alloc_pool <= msg_slot;
      scratch_free <= msg_valid && msg_unit_id == unit_id && msg_eot;
    end
  end
endmodule
`default_nettype wire

/* tb/tpb_row_loader.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side row loader: accepts entry read requests with random stalls
module tpb_row_loader
  import tpb_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic rd_valid,
  output logic rd_ready
);
  int seed = 18365;
  logic [31:0] r;
  // random stalls stress request holding
  always @(posedge core_clk) begin
    r = $random(seed);
    if (srst) begin
      rd_ready <= 1'b0;
    end else begin
      rd_ready <= (r[1:0] == 2'h0);
    end
  end
endmodule
`default_nettype wire

/* tb/tpb_payload_builder_props.sv */
`timescale 1ns/1ps
`default_nettype none
// protocol and ordering checks on the builder's ports
module tpb_payload_builder_props
  import tpb_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [15:0] rd_handle,
  input wire logic [7:0] rd_offset,
  input wire logic [7:0] rd_length,
  input wire logic [7:0] rd_dest_reg,
  input wire logic disp_done,
  input wire logic disp_ready,
  input wire logic hdr_valid,
  input wire logic [2:0] hdr_kind,
  input wire logic [7:0] hdr_reg,
  input wire logic msg_valid,
  input wire logic msg_eot,
  input wire logic msg_alloc,
  input wire logic [1:0] msg_slot,
  input wire logic [7:0] msg_link_id,
  input wire logic scratch_free,
  input wire logic alloc_req,
  input wire logic [1:0] alloc_pool,
  input wire logic own_write_seen,
  input wire logic [7:0] own_write_link
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [7:0] nd_q;
  logic nd_v_q;
  // next destination register expected within one dispatch
  always_ff @(posedge core_clk) begin
    if (rd_valid && rd_ready) nd_q <= rd_dest_reg + rd_length;
    if (srst || disp_done) nd_v_q <= 1'b0;
    else if (rd_valid && rd_ready) nd_v_q <= 1'b1;
  end
  property p_rd_hold;
    rd_valid && !rd_ready |=> rd_valid && $stable({rd_handle, rd_offset, rd_length, rd_dest_reg});
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read not held");
  property p_rd_gap;
    rd_valid && nd_v_q |-> rd_dest_reg == nd_q;
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("register gap");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_done_pulse;
    disp_done |=> !disp_done ##1 !disp_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_busy;
    hdr_valid |-> !disp_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_hdr_r0;
    hdr_valid && hdr_kind == TPB_HW_IDS |-> hdr_reg == 8'h00;
  endproperty
  a_hdr_r0: assert property (p_hdr_r0) else $error("id word misplaced");
  property p_own_link;
    own_write_seen |-> $past(msg_valid) && own_write_link == $past(msg_link_id);
  endproperty
  a_own_link: assert property (p_own_link) else $error("link wrong");
  property p_pool;
    alloc_req |-> $past(msg_valid && msg_alloc) && alloc_pool == $past(msg_slot);
  endproperty
  a_pool: assert property (p_pool) else $error("pool wrong");
  property p_free;
    scratch_free |-> $past(msg_valid && msg_eot);
  endproperty
  a_free: assert property (p_free) else $error("stray scratch free");
endmodule
bind tpb_payload_builder tpb_payload_builder_props i_props (.*);
`default_nettype wire

/* tb/thread_payload_builder_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module thread_payload_builder_tb_top
  import tpb_pkg::*;
;
  localparam logic [7:0] START = 8'h05;
  localparam logic [7:0] COFF = 8'h02;
  localparam logic [7:0] VOFF = 8'h01;
  localparam logic [7:0] VLEN = 8'h02;
  localparam logic [3:0] UNIT = 4'h5;
  int seed = 18365;
  int mismatches = 0;
  int tests_run = 0;
  logic core_clk = 1'b0, srst = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic disp_valid = 1'b0, disp_flip_strip = 1'b0, disp_two_vertices = 1'b0, disp_ready;
  logic [4:0] disp_topology = '0;
  logic [2:0] disp_vertex_count = '0, hdr_kind;
  logic [15:0] disp_const_handle = '0, disp_entry_handle0 = '0, disp_entry_handle1 = '0;
  logic [7:0] disp_link_id0 = '0, disp_link_id1 = '0, hdr_reg;
  logic hdr_valid, rd_valid, rd_ready, rd_swizzle, disp_done;
  logic [31:0] hdr_word;
  logic [15:0] rd_handle;
  logic [7:0] rd_offset, rd_length, rd_dest_reg, own_write_link;
  logic msg_valid = 1'b0, msg_alloc = 1'b0, msg_eot = 1'b0;
  logic [3:0] msg_unit_id = '0;
  logic [1:0] msg_slot = '0, alloc_pool;
  logic [7:0] msg_link_id = '0;
  logic own_write_seen, alloc_req, scratch_free;
  logic [65:0] q_r[$];
  logic [1:0] q_b[$];
  logic [40:0] q_rd[$];
  logic [31:0] sw[$];
  logic [5:0] seen;
  logic [65:0] er;
  logic [40:0] ed;
  logic [1:0] eb;

  tpb_payload_builder i_dut (.*);
  tpb_row_loader i_far (.*);

  initial forever #12.5 core_clk = ~core_clk;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_hi(ref logic s);
    for (int n = 0; n < 300; n++) begin
      @(posedge core_clk);
      if (s === 1'b1) return;
    end
    mismatches++;
    give_verdict();
  endtask

  // aw and w offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    q_b.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 300 && (aw || w); n++) begin
      @(posedge core_clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (aw || w) wait_hi(srst);
    @(posedge core_clk);
    s_axi_bready <= 1'b1;
    wait_hi(s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask

  // rready raised after the address
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] r);
    q_r.push_back({m, r, e & m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    wait_hi(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge core_clk);
    s_axi_rready <= 1'b1;
    wait_hi(s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic dispatch(input tpb_stage_t st, input logic tw, input logic [7:0] cl);
    logic [31:0] r;
    logic [7:0] dst;
    logic [5:0] em;
    int nv;
    axi_wr(TPB_OFF_CTRL, {16'h0000, START, UNIT, 1'b0, st}, TPB_RESP_OKAY);
    axi_wr(TPB_OFF_READ, {VLEN, VOFF, cl, COFF}, TPB_RESP_OKAY);
    r = $random(seed);
    disp_const_handle <= r[15:0];
    disp_entry_handle0 <= r[31:16];
    dst = START;
    if (cl != 8'h00) begin
      q_rd.push_back({r[15:0], COFF, cl, dst, st == TPB_STAGE_VS});
      dst = dst + cl;
    end
    nv = (st == TPB_STAGE_VS) ? (tw ? 2 : 1) : ((st == TPB_STAGE_WM) ? 1 : 2);
    q_rd.push_back({r[31:16], VOFF, VLEN, dst, st == TPB_STAGE_VS});
    r = $random(seed);
    if (nv == 2) q_rd.push_back({r[15:0], VOFF, VLEN, dst + VLEN, st == TPB_STAGE_VS});
    em = {st != TPB_STAGE_VS, st == TPB_STAGE_VS && tw, st != TPB_STAGE_WM, 3'b111};
    seen = '0;
    disp_entry_handle1 <= r[15:0];
    disp_topology <= r[20:16];
    disp_link_id0 <= r[31:24];
    disp_link_id1 <= r[23:16];
    disp_two_vertices <= tw;
    disp_vertex_count <= 3'h2;
    disp_valid <= 1'b1;
    wait_hi(disp_ready);
    disp_valid <= 1'b0;
    wait_hi(disp_done);
    `CHK("header kinds", em, seen)
    `CHK("reads left", 0, q_rd.size())
  endtask

  task automatic snoop(input logic [3:0] u, input logic [1:0] sl, input logic al, input logic eo);
    msg_valid <= 1'b1;
    msg_unit_id <= u;
    msg_slot <= sl;
    msg_link_id <= 8'h5A;
    msg_alloc <= al;
    msg_eot <= eo;
    @(posedge core_clk);
    msg_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  // oldest note against outputs
  always @(posedge core_clk) begin
    if (!srst && s_axi_bvalid && s_axi_bready) begin
      eb = q_b.pop_front();
      `CHK("bresp", eb, s_axi_bresp)
    end
    if (!srst && s_axi_rvalid && s_axi_rready) begin
      er = q_r.pop_front();
      `CHK("rdata", er[31:0], s_axi_rdata & er[65:34])
      `CHK("rresp", er[33:32], s_axi_rresp)
    end
    if (!srst && rd_valid && rd_ready) begin
      ed = q_rd.pop_front();
      `CHK("entry read", ed, {rd_handle, rd_offset, rd_length, rd_dest_reg, rd_swizzle})
    end
    if (!srst && hdr_valid) begin
      seen[hdr_kind] = 1'b1;
      if (hdr_kind == TPB_HW_SCRATCH) sw.push_back(hdr_word);
      if (hdr_kind == TPB_HW_IDS) `CHK("unit id", UNIT, hdr_word[3:0])
    end
  end

  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    axi_rd(TPB_OFF_CTRL, 32'hFFFFFFFF, TPB_CTRL_RST, TPB_RESP_OKAY);
    axi_rd(TPB_OFF_READ, 32'hFFFFFFFF, TPB_READ_RST, TPB_RESP_OKAY);
    axi_rd(8'h20, 32'hFFFFFFFF, 32'h00000000, TPB_RESP_SLVERR);
    axi_wr(8'h22, 32'h00000001, TPB_RESP_SLVERR);
    axi_wr(TPB_OFF_SCR_BASE, 32'h00004000, TPB_RESP_OKAY);
    axi_wr(TPB_OFF_SCR_SIZE, 32'h00000800, TPB_RESP_OKAY);
    dispatch(TPB_STAGE_VS, 1'b1, 8'h03);
    dispatch(TPB_STAGE_GS, 1'b0, 8'h00);
    dispatch(TPB_STAGE_CLIP, 1'b0, 8'h01);
    dispatch(TPB_STAGE_SF, 1'b0, 8'h03);
    // all slots busy
    @(posedge core_clk);
    `CHK("disp_ready", 1'b0, disp_ready)
    axi_rd(TPB_OFF_STATUS, 32'hFFFF000F, 32'h0004000F, TPB_RESP_OKAY);
    `CHK("scratch 0", 32'h00004000, sw[0])
    `CHK("scratch 1", 32'h00004800, sw[1])
    snoop(4'h3, 2'h1, 1'b1, 1'b0);
    `CHK("foreign alloc", 1'b0, alloc_req)
    snoop(UNIT, 2'h2, 1'b1, 1'b0);
    `CHK("alloc_req", 1'b1, alloc_req)
    `CHK("alloc_pool", 2'h2, alloc_pool)
    snoop(UNIT, 2'h1, 1'b0, 1'b0);
    `CHK("own_write_seen", 1'b1, own_write_seen)
    `CHK("own_write_link", 8'h5A, own_write_link)
    for (int i = 0; i < 4; i++) begin
      snoop(UNIT, 2'(i), 1'b0, 1'b1);
      `CHK("scratch_free", 1'b1, scratch_free)
    end
    dispatch(TPB_STAGE_WM, 1'b0, 8'h02);
    dispatch(TPB_STAGE_VS, 1'b0, 8'h00);
    axi_rd(TPB_OFF_STATUS, 32'hFFFF0000, 32'h00060000, TPB_RESP_OKAY);
    give_verdict();
  end
endmodule
`default_nettype wire
